// File: core/cgwd_pkg.sv
// Purpose: Shared constants for the clock gating and frequency watchdog block
// Assumes: 10 MHz core clock, byte-wide register file reached over a two-wire serial link
// Notes: Each field position and reset value is named once here, except mid gate bits [3:0] and the enable and flag resets
package cgwd_pkg;
    // Register offsets
    localparam logic [7:0] OFFS_GATE_A = 8'h03;
    localparam logic [7:0] OFFS_MID_GATE = 8'h04;
    localparam logic [7:0] OFFS_WD_CTRL = 8'h05;
    localparam logic [7:0] OFFS_WD_COUNT = 8'h06;
    // Reset values
    localparam logic [7:0] RST_GATE_A = 8'hf7;
    localparam logic [7:0] RST_MID_GATE = 8'hff;
    localparam logic [7:0] RST_WD_COUNT = 8'h08;
    localparam logic [4:0] RST_SAFE_FREQ = 5'h00;
    localparam logic [4:0] RST_FREQ_CODE = 5'h00;
    // Output gating field positions
    localparam int GATE_DOT = 7;
    localparam int GATE_USB = 6;
    localparam int GATE_REF = 5;
    localparam int GATE_ALT_SEL = 3;
    localparam int GATE_PCI_F1 = 1;
    localparam int GATE_PCI_F0 = 0;
    // Watchdog control field positions
    localparam int WD_EN_BIT = 6;
    localparam int WD_EXP_BIT = 5;
    localparam int SAFE_HI = 4;
    localparam int SAFE_LO = 0;
    // Tick timing
    localparam int unsigned CLK_HZ = 10000000;
    localparam int unsigned WD_TICK_MS = 250;
    localparam int unsigned WD_TICK_CYCLES = (CLK_HZ / 1000) * WD_TICK_MS;
    localparam int PRESC_W = 22;
    // Serial link
    localparam logic [6:0] SLAVE_ADDR = 7'h2a; // Arbitrary default address
    localparam logic [3:0] BITS_PER_BYTE = 4'h8;
    localparam logic [3:0] LAST_BIT = 4'h7;
endpackage

// File: core/cgwd_serial_slave.sv
// Purpose: Two-wire serial slave giving byte writes and reads at an offset
// Assumes: scl and sda already synchronous to clk_i; oversampled by the core clock
// Notes: Offset auto-increments after each data byte; reads take no side effects
`timescale 1ns/1ps
module cgwd_serial_slave (
    // Clock and reset
    input wire logic clk_i,
    input wire logic arst_n_i,
    // Serial pins
    input wire logic scl_i,
    input wire logic sda_i,
    output logic sda_o,
    output logic sda_oe_o,
    // Register side
    output logic wr_stb_o,
    output logic [7:0] wr_addr_o,
    output logic [7:0] wr_data_o,
    output logic [7:0] rd_addr_o,
    input wire logic [7:0] rd_data_i
);
    typedef enum logic [3:0] {
        S_IDLE, S_ADDR, S_ACK_ADDR, S_OFFS, S_ACK_OFFS, S_WDATA, S_ACK_W, S_RDATA, S_ACK_R
    } cgwd_sst_t;

    cgwd_sst_t st_r, st_nxt;
    logic [3:0] bit_r, bit_nxt;
    logic [7:0] sh_r, sh_nxt;
    logic [7:0] offs_r, offs_nxt;
    logic rw_r, rw_nxt;
    logic oe_r, oe_nxt;
    logic stb_r, stb_nxt;
    logic [7:0] wd_r, wd_nxt;
    logic scl_q_r, sda_q_r;
    logic scl_rise, scl_fall, start_c, stop_c;

    // Pin edges seen against last sample
    assign scl_rise = scl_i && !scl_q_r;
    assign scl_fall = !scl_i && scl_q_r;
    assign start_c = scl_i && scl_q_r && sda_q_r && !sda_i;
    assign stop_c = scl_i && scl_q_r && !sda_q_r && sda_i;

    // Protocol next state
    always_comb begin
        st_nxt = st_r;
        bit_nxt = bit_r;
        sh_nxt = sh_r;
        offs_nxt = offs_r;
        rw_nxt = rw_r;
        oe_nxt = oe_r;
        stb_nxt = 1'b0;
        wd_nxt = wd_r;
        if (start_c) begin
            st_nxt = S_ADDR;
            bit_nxt = 4'h0;
            oe_nxt = 1'b0;
        end else if (stop_c) begin
            st_nxt = S_IDLE;
            oe_nxt = 1'b0;
        end else if (scl_rise) begin
            case (st_r)
                S_ADDR, S_OFFS, S_WDATA: begin
                    sh_nxt = {sh_r[6:0], sda_i};
                    bit_nxt = bit_r + 4'h1;
                end
                S_ACK_R: begin
                    if (sda_i) begin
                        st_nxt = S_IDLE; // Master ends the read
                    end
                end
                default: begin
                end
            endcase
        end else if (scl_fall) begin
            case (st_r)
                S_ADDR: begin
                    if (bit_r == cgwd_pkg::BITS_PER_BYTE) begin
                        if (sh_r[7:1] == cgwd_pkg::SLAVE_ADDR) begin
                            oe_nxt = 1'b1;
                            rw_nxt = sh_r[0];
                            st_nxt = S_ACK_ADDR;
                        end else begin
                            st_nxt = S_IDLE;
                        end
                    end
                end
                S_ACK_ADDR, S_ACK_R: begin
                    bit_nxt = 4'h0;
                    if (rw_r) begin
                        sh_nxt = rd_data_i; // Byte latched before first bit goes out
                        oe_nxt = !rd_data_i[7];
                        st_nxt = S_RDATA;
                    end else begin
                        oe_nxt = 1'b0;
                        st_nxt = S_OFFS;
                    end
                end
                S_OFFS: begin
                    if (bit_r == cgwd_pkg::BITS_PER_BYTE) begin
                        offs_nxt = sh_r;
                        oe_nxt = 1'b1;
                        st_nxt = S_ACK_OFFS;
                    end
                end
                S_ACK_OFFS, S_ACK_W: begin
                    oe_nxt = 1'b0;
                    bit_nxt = 4'h0;
                    st_nxt = S_WDATA;
                end
                S_WDATA: begin
                    if (bit_r == cgwd_pkg::BITS_PER_BYTE) begin
                        stb_nxt = 1'b1;
                        wd_nxt = sh_r;
                        oe_nxt = 1'b1;
                        st_nxt = S_ACK_W;
                        offs_nxt = offs_r + 8'h01;
                    end
                end
                S_RDATA: begin
                    bit_nxt = bit_r + 4'h1;
                    sh_nxt = {sh_r[6:0], 1'b0};
                    if (bit_r == cgwd_pkg::LAST_BIT) begin
                        oe_nxt = 1'b0; // Release for the master acknowledge
                        offs_nxt = offs_r + 8'h01;
                        st_nxt = S_ACK_R;
                    end else begin
                        oe_nxt = !sh_r[6];
                    end
                end
                default: begin
                end
            endcase
        end
    end

    // Protocol registers
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            st_r <= S_IDLE;
            bit_r <= 4'h0;
            sh_r <= 8'h00;
            offs_r <= 8'h00;
            rw_r <= 1'b0;
            oe_r <= 1'b0;
            stb_r <= 1'b0;
            wd_r <= 8'h00;
            scl_q_r <= 1'b1;
            sda_q_r <= 1'b1;
        end else begin
            st_r <= st_nxt;
            bit_r <= bit_nxt;
            sh_r <= sh_nxt;
            offs_r <= offs_nxt;
            rw_r <= rw_nxt;
            oe_r <= oe_nxt;
            stb_r <= stb_nxt;
            wd_r <= wd_nxt;
            scl_q_r <= scl_i;
            sda_q_r <= sda_i;
        end
    end

    // Write address lags offset increment by one
    assign sda_o = 1'b0;
    assign sda_oe_o = oe_r;
    assign wr_stb_o = stb_r;
    assign wr_addr_o = offs_r - 8'h01;
    assign wr_data_o = wd_r;
    assign rd_addr_o = offs_r;
endmodule

// File: core/cgwd_top.sv
// Purpose: Output gating registers and frequency watchdog with fallback reload
// Assumes: Strap pins valid while power_good_strobe_n_i is low; inputs synchronous to clk_i
// Notes: Gate outputs are enables for the clock drivers, not clocks themselves
`timescale 1ns/1ps
module cgwd_top #(
    parameter int unsigned TICK_CYCLES = cgwd_pkg::WD_TICK_CYCLES
) (
    // Clock and reset
    input wire logic clk_i,
    input wire logic arst_n_i,
    // Serial link
    input wire logic scl_i,
    input wire logic sda_i,
    output logic sda_o,
    output logic sda_oe_o,
    // Power good and straps
    input wire logic power_good_strobe_n_i,
    input wire logic strap_wd_enable_i,
    input wire logic [4:0] strap_freq_select_i,
    // Loose control bit held elsewhere
    input wire logic fallback_reload_select_i,
    // Gating enables
    output logic dot_clock_en_o,
    output logic usb_clock_en_o,
    output logic ref_clock_en_o,
    output logic free_pci_en0_o,
    output logic free_pci_en1_o,
    output logic alt_output_select_o,
    output logic [3:0] mid_clock_en_o,
    // Frequency control
    output logic [4:0] freq_select_o,
    output logic divisor_program_clear_o,
    output logic watchdog_expired_o
);
    logic wr_stb;
    logic [7:0] wr_addr, wr_data, rd_addr;
    logic [7:0] rd_data;
    logic [7:0] gate_a_r, gate_a_nxt;
    logic [7:0] mid_gate_r, mid_gate_nxt;
    logic [4:0] safe_r, safe_nxt;
    logic [7:0] count_r, count_nxt;
    logic counting_r, counting_nxt;
    logic flag_r, flag_nxt;
    logic [cgwd_pkg::PRESC_W-1:0] presc_r, presc_nxt;
    logic [4:0] strap_code_r, strap_code_nxt;
    logic [4:0] freq_r, freq_nxt;
    logic div_clr_r, div_clr_nxt;
    logic power_good, wr_ctrl, wr_count, start_req, stop_req, expire, tick;

    // Offset match shared by write and read decode
    function automatic logic reg_hit(input logic [7:0] a, input logic [7:0] offs);
        reg_hit = (a == offs);
    endfunction

    cgwd_serial_slave u_link (
        .clk_i(clk_i),
        .arst_n_i(arst_n_i),
        .scl_i(scl_i),
        .sda_i(sda_i),
        .sda_o(sda_o),
        .sda_oe_o(sda_oe_o),
        .wr_stb_o(wr_stb),
        .wr_addr_o(wr_addr),
        .wr_data_o(wr_data),
        .rd_addr_o(rd_addr),
        .rd_data_i(rd_data)
    );

    // Watchdog events
    assign power_good = !power_good_strobe_n_i;
    assign wr_ctrl = wr_stb && reg_hit(wr_addr, cgwd_pkg::OFFS_WD_CTRL);
    assign wr_count = wr_stb && reg_hit(wr_addr, cgwd_pkg::OFFS_WD_COUNT);
    assign start_req = wr_ctrl && wr_data[cgwd_pkg::WD_EN_BIT];
    assign stop_req = wr_ctrl && !wr_data[cgwd_pkg::WD_EN_BIT];
    assign expire = counting_r && (count_r == 8'h00);
    // Prescaler comparison; long count kept as a parameter for simulation
    assign tick = counting_r && (presc_r == cgwd_pkg::PRESC_W'(TICK_CYCLES - 1));

    // Gating register next values
    always_comb begin
        gate_a_nxt = gate_a_r;
        mid_gate_nxt = mid_gate_r;
        if (wr_stb && reg_hit(wr_addr, cgwd_pkg::OFFS_GATE_A)) begin
            gate_a_nxt = wr_data;
        end
        if (wr_stb && reg_hit(wr_addr, cgwd_pkg::OFFS_MID_GATE)) begin
            mid_gate_nxt = wr_data;
        end
    end

    // Watchdog next values; set of the flag wins over restart
    always_comb begin
        counting_nxt = counting_r;
        flag_nxt = flag_r;
        safe_nxt = safe_r;
        count_nxt = count_r;
        presc_nxt = presc_r + cgwd_pkg::PRESC_W'(1);
        strap_code_nxt = strap_code_r;
        freq_nxt = freq_r;
        div_clr_nxt = expire;
        if (wr_ctrl) begin
            safe_nxt = wr_data[cgwd_pkg::SAFE_HI:cgwd_pkg::SAFE_LO];
        end
        if (power_good) begin
            counting_nxt = strap_wd_enable_i;
            strap_code_nxt = strap_freq_select_i;
            freq_nxt = strap_freq_select_i;
        end else if (start_req) begin
            counting_nxt = 1'b1;
        end else if (stop_req || expire) begin
            counting_nxt = 1'b0;
        end
        if (expire) begin
            flag_nxt = 1'b1;
        end else if (start_req) begin
            flag_nxt = 1'b0;
        end
        if (expire && !power_good) begin
            freq_nxt = fallback_reload_select_i ? safe_r : strap_code_r;
        end
        // Restart realigns the tick so the first period is full length
        if (!counting_r || start_req || tick) begin
            presc_nxt = '0;
        end
        if (wr_count) begin
            count_nxt = wr_data; // Host write beats a same-cycle decrement
        end else if (tick && (count_r != 8'h00)) begin
            count_nxt = count_r - 8'h01;
        end
    end

    // Register read mux
    always_comb begin
        rd_data = 8'h00;
        if (reg_hit(rd_addr, cgwd_pkg::OFFS_GATE_A)) begin
            rd_data = gate_a_r;
        end else if (reg_hit(rd_addr, cgwd_pkg::OFFS_MID_GATE)) begin
            rd_data = mid_gate_r;
        end else if (reg_hit(rd_addr, cgwd_pkg::OFFS_WD_CTRL)) begin
            rd_data[cgwd_pkg::WD_EN_BIT] = counting_r;
            rd_data[cgwd_pkg::WD_EXP_BIT] = flag_r;
            rd_data[cgwd_pkg::SAFE_HI:cgwd_pkg::SAFE_LO] = safe_r;
        end else if (reg_hit(rd_addr, cgwd_pkg::OFFS_WD_COUNT)) begin
            rd_data = count_r;
        end
    end

    // State registers
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            gate_a_r <= cgwd_pkg::RST_GATE_A;
            mid_gate_r <= cgwd_pkg::RST_MID_GATE;
            safe_r <= cgwd_pkg::RST_SAFE_FREQ;
            count_r <= cgwd_pkg::RST_WD_COUNT;
            counting_r <= 1'b0;
            flag_r <= 1'b0;
            presc_r <= '0;
            strap_code_r <= cgwd_pkg::RST_FREQ_CODE;
            freq_r <= cgwd_pkg::RST_FREQ_CODE;
            div_clr_r <= 1'b0;
        end else begin
            gate_a_r <= gate_a_nxt;
            mid_gate_r <= mid_gate_nxt;
            safe_r <= safe_nxt;
            count_r <= count_nxt;
            counting_r <= counting_nxt;
            flag_r <= flag_nxt;
            presc_r <= presc_nxt;
            strap_code_r <= strap_code_nxt;
            freq_r <= freq_nxt;
            div_clr_r <= div_clr_nxt;
        end
    end

    // Outputs straight from registers
    assign dot_clock_en_o = gate_a_r[cgwd_pkg::GATE_DOT];
    assign usb_clock_en_o = gate_a_r[cgwd_pkg::GATE_USB];
    assign ref_clock_en_o = gate_a_r[cgwd_pkg::GATE_REF];
    assign free_pci_en1_o = gate_a_r[cgwd_pkg::GATE_PCI_F1];
    assign free_pci_en0_o = gate_a_r[cgwd_pkg::GATE_PCI_F0];
    assign alt_output_select_o = gate_a_r[cgwd_pkg::GATE_ALT_SEL];
    assign mid_clock_en_o = mid_gate_r[3:0];
    assign freq_select_o = freq_r;
    assign divisor_program_clear_o = div_clr_r;
    assign watchdog_expired_o = flag_r;

    a_count_decrement: assert property (@(posedge clk_i) disable iff (!arst_n_i)
        tick && (count_r != 8'h00) && !wr_count |=> count_r == $past(count_r) - 8'h01)
        else $error("count did not decrement on tick");
    a_expire_flag: assert property (@(posedge clk_i) disable iff (!arst_n_i)
        expire |=> flag_r && watchdog_expired_o)
        else $error("expiry did not set flag");
    a_flag_host_safe: assert property (@(posedge clk_i) disable iff (!arst_n_i)
        wr_ctrl && !flag_r && !expire |=> !flag_r)
        else $error("host write set expiry flag");
    a_restart_clears: assert property (@(posedge clk_i) disable iff (!arst_n_i)
        start_req && !expire && !power_good |=> !flag_r && counting_r)
        else $error("restart did not clear flag");
    a_safe_reload: assert property (@(posedge clk_i) disable iff (!arst_n_i)
        expire && fallback_reload_select_i && !power_good |=> freq_select_o == $past(safe_r))
        else $error("safe code not reloaded");
    a_strap_reload: assert property (@(posedge clk_i) disable iff (!arst_n_i)
        expire && !fallback_reload_select_i && !power_good
        |=> freq_select_o == $past(strap_code_r))
        else $error("strap code not reloaded");
    a_div_clear: assert property (@(posedge clk_i) disable iff (!arst_n_i)
        $rose(expire) |=> divisor_program_clear_o ##1 (divisor_program_clear_o == $past(expire)))
        else $error("divisor enable clear missing");
    a_strap_enable: assert property (@(posedge clk_i) disable iff (!arst_n_i)
        power_good |=> counting_r == $past(strap_wd_enable_i))
        else $error("strap enable not captured");
    a_read_count: assert property (@(posedge clk_i) disable iff (!arst_n_i)
        reg_hit(rd_addr, cgwd_pkg::OFFS_WD_COUNT) |-> rd_data == count_r)
        else $error("count readback wrong");
    a_read_state: assert property (@(posedge clk_i) disable iff (!arst_n_i)
        reg_hit(rd_addr, cgwd_pkg::OFFS_WD_CTRL) |-> rd_data[cgwd_pkg::WD_EN_BIT] == counting_r)
        else $error("enable readback not live state");
    a_gate_write: assert property (@(posedge clk_i) disable iff (!arst_n_i)
        wr_stb && reg_hit(wr_addr, cgwd_pkg::OFFS_GATE_A)
        |=> alt_output_select_o == $past(wr_data[cgwd_pkg::GATE_ALT_SEL]))
        else $error("alternate select not written");
    a_stop_write: assert property (@(posedge clk_i) disable iff (!arst_n_i)
        stop_req && !power_good |=> !counting_r ##1 $stable(count_r) || $past(wr_count))
        else $error("stop did not halt count");

    // Counting, expiry and tick checks; restart and power good may extend a pulse
    a_clear_single: assert property (@(posedge clk_i) disable iff (!arst_n_i)
        divisor_program_clear_o && !$past(start_req) && !$past(power_good)
        |=> !divisor_program_clear_o)
        else $error("divisor clear longer than one cycle");
    a_expire_stops: assert property (@(posedge clk_i) disable iff (!arst_n_i)
        expire && !start_req && !power_good && !wr_count |=> !counting_r && count_r == 8'h00)
        else $error("expiry did not stop the count");
    a_count_hold: assert property (@(posedge clk_i) disable iff (!arst_n_i)
        !tick && !wr_count |=> $stable(count_r))
        else $error("count moved without tick or write");
    a_tick_restart: assert property (@(posedge clk_i) disable iff (!arst_n_i)
        start_req && !power_good |=> presc_r == '0)
        else $error("restart did not realign tick");
    a_flag_sticky: assert property (@(posedge clk_i) disable iff (!arst_n_i)
        flag_r && !start_req |=> flag_r)
        else $error("expiry flag cleared without restart");

    // Register and frequency output checks
    a_freq_hold: assert property (@(posedge clk_i) disable iff (!arst_n_i)
        !expire && !power_good |=> $stable(freq_select_o))
        else $error("frequency code moved without cause");
    a_strap_freq: assert property (@(posedge clk_i) disable iff (!arst_n_i)
        power_good |=> freq_select_o == $past(strap_freq_select_i))
        else $error("strap code not captured");
    a_mid_write: assert property (@(posedge clk_i) disable iff (!arst_n_i)
        wr_stb && reg_hit(wr_addr, cgwd_pkg::OFFS_MID_GATE)
        |=> mid_clock_en_o == $past(wr_data[3:0]))
        else $error("mid clock gates not written");
    a_gate_bits: assert property (@(posedge clk_i) disable iff (!arst_n_i)
        wr_stb && reg_hit(wr_addr, cgwd_pkg::OFFS_GATE_A)
        |=> dot_clock_en_o == $past(wr_data[cgwd_pkg::GATE_DOT])
        && free_pci_en0_o == $past(wr_data[cgwd_pkg::GATE_PCI_F0]))
        else $error("gating bits not written");
endmodule

// File: verif/cgwd_host.sv
// Purpose: Host model that speaks the two-wire register link
// Assumes: Data wire has a pull-up; host changes lines after falling clk
// Notes: Each line phase lasts four core cycles, except the two-cycle clock low before a repeated start
`timescale 1ns/1ps
module cgwd_host (
    // Core clock and resolved data wire
    input wire logic clk_i,
    input wire logic sda_i,
    // Host drives clock; data 1 means released
    output logic scl_o,
    output logic sda_o
);
    initial begin
        scl_o = 1'b1;
        sda_o = 1'b1;
    end
    // Wait whole core cycles on the falling edge
    task automatic hw(input int n);
        repeat (n) @(negedge clk_i);
    endtask
    // Start or repeated start
    task automatic start();
        sda_o = 1'b1;
        hw(2);
        scl_o = 1'b1;
        hw(4);
        sda_o = 1'b0;
        hw(4);
        scl_o = 1'b0;
    endtask
    task automatic stop();
        hw(1);
        sda_o = 1'b0;
        hw(3);
        scl_o = 1'b1;
        hw(4);
        sda_o = 1'b1;
        hw(4);
    endtask
    // Data moves one cycle after the clock fall, so no false start
    task automatic clk_bit(input logic b, output logic s);
        hw(1);
        sda_o = b;
        hw(3);
        scl_o = 1'b1;
        hw(2);
        s = sda_i;
        hw(2);
        scl_o = 1'b0;
    endtask
    task automatic send(input logic [7:0] d, output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--) clk_bit(d[i], s);
        clk_bit(1'b1, s);
        ack = ~s;
    endtask
    // Last byte is refused so the device lets go of the wire
    task automatic recv(input logic last, output logic [7:0] d);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            clk_bit(1'b1, s);
            d[i] = s;
        end
        clk_bit(last, s);
    endtask
endmodule

// File: verif/cgwd_top_tb.sv
// Purpose: Self-checking bench for gating registers and watchdog
// Assumes: Short tick parameter so a timeout lasts a few thousand cycles
// Notes: All register traffic goes through the host model
`timescale 1ns/1ps
module cgwd_top_tb;
    localparam int unsigned TICK = 2000;
    localparam logic [4:0] STRAP = 5'h15;
    localparam logic [4:0] SAFE = 5'h0c;
    logic clk_i, arst_n_i, pg_n, strap_en, fb_sel, scl, host_sda, sda_o, sda_oe;
    logic dot_en, usb_en, ref_en, pci0, pci1, alt_sel, clr, expd, clr_seen;
    logic [4:0] strap_code, freq_sel;
    logic [3:0] mid_en;
    logic [7:0] d;
    int bad_count, checked, n;
    wire logic sda_w = host_sda & (sda_o | ~sda_oe);
    cgwd_top #(.TICK_CYCLES(TICK)) u_cgwd_top (.clk_i(clk_i), .arst_n_i(arst_n_i),
        .scl_i(scl), .sda_i(sda_w), .sda_o(sda_o), .sda_oe_o(sda_oe),
        .power_good_strobe_n_i(pg_n), .strap_wd_enable_i(strap_en),
        .strap_freq_select_i(strap_code), .fallback_reload_select_i(fb_sel),
        .dot_clock_en_o(dot_en), .usb_clock_en_o(usb_en), .ref_clock_en_o(ref_en),
        .free_pci_en0_o(pci0), .free_pci_en1_o(pci1), .alt_output_select_o(alt_sel),
        .mid_clock_en_o(mid_en), .freq_select_o(freq_sel), .divisor_program_clear_o(clr),
        .watchdog_expired_o(expd));
    cgwd_host u_cgwd_host (.clk_i(clk_i), .sda_i(sda_w), .scl_o(scl), .sda_o(host_sda));
    // Clock
    initial begin
        clk_i = 1'b0;
        forever #50 clk_i = ~clk_i;
    end
    // Clear pulse lasts one cycle, so keep a sticky copy taken mid-cycle
    always @(negedge clk_i) if (clr === 1'b1) clr_seen <= 1'b1;
    task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
        checked++;
        if (got !== exp) begin
            bad_count++;
            $display("ERROR %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask
    task automatic stop_test();
        $display("checks %0d mismatches %0d", checked, bad_count);
        if (bad_count == 0 && checked > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    task automatic wr(input logic [7:0] off, input logic [7:0] v);
        logic a, b, c;
        u_cgwd_host.start();
        u_cgwd_host.send({cgwd_pkg::SLAVE_ADDR, 1'b0}, a);
        u_cgwd_host.send(off, b);
        u_cgwd_host.send(v, c);
        u_cgwd_host.stop();
        chk({5'h0, a, b, c}, 8'h07, "write acks");
    endtask
    task automatic rd(input logic [7:0] off, input logic [7:0] exp);
        logic a, b, c;
        logic [7:0] v;
        u_cgwd_host.start();
        u_cgwd_host.send({cgwd_pkg::SLAVE_ADDR, 1'b0}, a);
        u_cgwd_host.send(off, b);
        u_cgwd_host.start();
        u_cgwd_host.send({cgwd_pkg::SLAVE_ADDR, 1'b1}, c);
        u_cgwd_host.recv(1'b1, v);
        u_cgwd_host.stop();
        chk({5'h0, a, b, c}, 8'h07, "read acks");
        chk(v, exp, "read data");
    endtask
    // Bounded wait for the expiry flag; n counts cycles waited
    task automatic wait_exp();
        n = 0;
        while (expd !== 1'b1 && n < 4 * TICK) begin
            @(negedge clk_i);
            n++;
        end
        if (expd !== 1'b1) begin
            bad_count++;
            $display("ERROR %0t expiry never came", $time);
            stop_test();
        end
    endtask
    task automatic t_reset();
        chk({dot_en, usb_en, ref_en, 1'b0, alt_sel, 1'b0, pci1, pci0}, 8'he3, "gates");
        chk({4'h0, mid_en}, 8'h0f, "mid gates");
        chk({3'h0, freq_sel}, {3'h0, STRAP}, "strap freq");
        rd(cgwd_pkg::OFFS_GATE_A, 8'hf7);
        rd(cgwd_pkg::OFFS_MID_GATE, 8'hff);
        rd(cgwd_pkg::OFFS_WD_CTRL, 8'h00);
        rd(cgwd_pkg::OFFS_WD_COUNT, 8'h08);
        rd(8'h07, 8'h00);
        $display("t_reset done");
    endtask
    task automatic t_gating();
        wr(cgwd_pkg::OFFS_GATE_A, 8'h08);
        chk({dot_en, usb_en, ref_en, 1'b0, alt_sel, 1'b0, pci1, pci0}, 8'h08, "off");
        rd(cgwd_pkg::OFFS_GATE_A, 8'h08);
        wr(cgwd_pkg::OFFS_MID_GATE, 8'ha5);
        chk({4'h0, mid_en}, 8'h05, "mid set");
        rd(cgwd_pkg::OFFS_MID_GATE, 8'ha5);
        wr(cgwd_pkg::OFFS_GATE_A, 8'hf7);
        chk({7'h0, alt_sel}, 8'h00, "alt back");
        $display("t_gating done");
    endtask
    // Two-byte write and two-byte read: offset increment and master acknowledge
    task automatic t_burst();
        logic a, b, c, e;
        logic [7:0] v0, v1;
        u_cgwd_host.start();
        u_cgwd_host.send({cgwd_pkg::SLAVE_ADDR, 1'b0}, a);
        u_cgwd_host.send(cgwd_pkg::OFFS_GATE_A, b);
        u_cgwd_host.send(8'h5a, c);
        u_cgwd_host.send(8'h3c, e);
        u_cgwd_host.stop();
        chk({4'h0, a, b, c, e}, 8'h0f, "burst write acks");
        chk({dot_en, usb_en, ref_en, 1'b0, alt_sel, 1'b0, pci1, pci0}, 8'h4a, "gate2");
        chk({4'h0, mid_en}, 8'h0c, "burst mid");
        u_cgwd_host.start();
        u_cgwd_host.send({cgwd_pkg::SLAVE_ADDR, 1'b0}, a);
        u_cgwd_host.send(cgwd_pkg::OFFS_GATE_A, b);
        u_cgwd_host.start();
        u_cgwd_host.send({cgwd_pkg::SLAVE_ADDR, 1'b1}, c);
        u_cgwd_host.recv(1'b0, v0);
        u_cgwd_host.recv(1'b1, v1);
        u_cgwd_host.stop();
        chk({5'h0, a, b, c}, 8'h07, "burst read acks");
        chk(v0, 8'h5a, "burst first");
        chk(v1, 8'h3c, "burst second");
        $display("t_burst done");
    endtask
    task automatic t_safe();
        fb_sel = 1'b1;
        wr(cgwd_pkg::OFFS_WD_COUNT, 8'h03);
        clr_seen = 1'b0;
        wr(cgwd_pkg::OFFS_WD_CTRL, {3'h2, SAFE});
        rd(cgwd_pkg::OFFS_WD_CTRL, {3'h2, SAFE});
        rd(cgwd_pkg::OFFS_WD_COUNT, 8'h03);
        repeat (TICK) @(negedge clk_i);
        rd(cgwd_pkg::OFFS_WD_COUNT, 8'h02);
        wait_exp();
        @(negedge clk_i);
        chk({3'h0, freq_sel}, {3'h0, SAFE}, "safe reload");
        chk({7'h0, clr_seen}, 8'h01, "divisor clear");
        rd(cgwd_pkg::OFFS_WD_CTRL, {3'h1, SAFE});
        wr(cgwd_pkg::OFFS_WD_CTRL, {3'h0, SAFE});
        rd(cgwd_pkg::OFFS_WD_CTRL, {3'h1, SAFE});
        rd(cgwd_pkg::OFFS_WD_COUNT, 8'h00);
        $display("t_safe done");
    endtask
    task automatic t_strap();
        fb_sel = 1'b0;
        wr(cgwd_pkg::OFFS_WD_COUNT, 8'h01);
        wr(cgwd_pkg::OFFS_WD_CTRL, {3'h2, SAFE});
        chk({7'h0, expd}, 8'h00, "restart clears");
        wait_exp();
        chk({7'h0, n >= TICK - 40 && n <= TICK + 10}, 8'h01, "one tick");
        chk({3'h0, freq_sel}, {3'h0, STRAP}, "strap reload");
        wr(cgwd_pkg::OFFS_WD_COUNT, 8'h02);
        wr(cgwd_pkg::OFFS_WD_CTRL, 8'h40);
        wr(cgwd_pkg::OFFS_WD_CTRL, 8'h20);
        rd(cgwd_pkg::OFFS_WD_CTRL, 8'h00);
        repeat (3 * TICK) @(negedge clk_i);
        chk({7'h0, expd}, 8'h00, "stopped");
        rd(cgwd_pkg::OFFS_WD_COUNT, 8'h02);
        $display("t_strap done");
    endtask
    // Wrong address is ignored, then a new strap capture starts counting
    task automatic t_refuse();
        logic a;
        u_cgwd_host.start();
        u_cgwd_host.send({7'h2b, 1'b0}, a);
        u_cgwd_host.stop();
        chk({7'h0, a}, 8'h00, "foreign address");
        strap_en = 1'b1;
        pg_n = 1'b0;
        repeat (4) @(negedge clk_i);
        pg_n = 1'b1;
        rd(cgwd_pkg::OFFS_WD_CTRL, 8'h40);
        $display("t_refuse done");
    endtask
    initial begin
        arst_n_i = 1'b0;
        pg_n = 1'b0;
        strap_en = 1'b0;
        strap_code = STRAP;
        fb_sel = 1'b0;
        clr_seen = 1'b0;
        bad_count = 0;
        checked = 0;
        repeat (6) @(negedge clk_i);
        arst_n_i = 1'b1;
        repeat (3) @(negedge clk_i);
        pg_n = 1'b1;
        repeat (2) @(negedge clk_i);
        t_reset();
        t_gating();
        t_burst();
        t_safe();
        t_strap();
        t_refuse();
        stop_test();
    end
endmodule
